//--- sdp_controller.sv
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module sdp_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 16
) (
	input  wire logic                       ref_clk,
	input  wire logic                       rst_b,
	input  wire logic                       in_valid,
	output logic                            in_ready,
	input  wire logic [W-1:0]               in_data,
	output logic                            out_valid,
	input  wire logic                       out_ready,
	output logic [W-1:0]                    out_data,
	output logic [$clog2(DEPTH):0]          level
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
	} sdp_fifo_st_t;

	sdp_fifo_st_t   q;
	sdp_fifo_st_t   n;
	logic [W-1:0]   mem [DEPTH];
	logic           push;
	logic           pop;

	assign in_ready  = (q.cnt != (AW+1)'(DEPTH));
	assign out_valid = (q.cnt != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb
	begin
		n = q;
		if (push)
			n.wp = AW'(q.wp + 1'b1);
		if (pop)
			n.rp = AW'(q.rp + 1'b1);
		n.cnt = (AW+1)'(q.cnt + push - pop);
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			q <= '0;
		else
			q <= n;
	end

	always_ff @(posedge ref_clk)
	begin
		if (push)
			mem[q.wp] <= in_data;
	end

	assign out_data = mem[q.rp];
	assign level    = q.cnt;
endmodule

module sdp_controller #(
	parameter int DW      = sdp_pkg::DATA_W,
	parameter int REF_GAP = sdp_pkg::REF_GAP_CYC
) (
	input  wire logic                        ref_clk,
	input  wire logic                        rst_b,
	sdp_link_if.ctl                          link,
	input  wire logic [sdp_pkg::REG_AW-1:0]  reg_addr,
	input  wire logic [31:0]                 reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic [31:0]                      reg_rdata
);
	import sdp_pkg::*;

	localparam int RCW = $clog2(REF_GAP + 1);
	localparam int LW  = $clog2(FIFO_DEPTH) + 1;

	typedef enum logic [2:0] {
		ST_INIT_PRE = 3'h0,
		ST_INIT_MRS = 3'h1,
		ST_IDLE     = 3'h2,
		ST_WAIT     = 3'h3,
		ST_RDWAIT   = 3'h4
	} sdp_cst_t;

	typedef struct packed {
		sdp_cst_t        st;
		logic            sel_b;
		sdp_cmd_t        rcw;
		logic [1:0]      bank;
		logic [11:0]     addr;
		logic [DW-1:0]   dq;
		logic            dq_oe;
		logic [5:0]      op;
		logic            pend;
		logic [11:0]     areg;
		logic [DW-1:0]   wdata;
		logic [1:0]      mask;
		logic            gate_req;
		logic [3:0]      cnt;
		logic [RCW-1:0]  rcnt;
		logic            ref_due;
		logic [31:0]     rdata;
	} sdp_ctl_st_t;

	localparam sdp_ctl_st_t RST = '{st: ST_INIT_PRE, sel_b: 1'b1,
		rcw: CMD_NOP, default: '0};

	sdp_ctl_st_t     q;
	sdp_ctl_st_t     n;
	logic            f_in_valid;
	logic            f_in_ready;
	logic            f_out_valid;
	logic            f_out_ready;
	logic [DW-1:0]   f_out_data;
	logic [LW-1:0]   f_level;
	sdp_cmd_t        op;

	assign op          = sdp_cmd_t'(q.op[CMD_OP_LSB +: 3]);
	assign f_in_valid  = (q.st == ST_RDWAIT) && (q.cnt == 4'h0);
	assign f_out_ready = reg_rd && (reg_addr == REG_RDATA);

	sdp_fifo #(.W(DW), .DEPTH(FIFO_DEPTH)) u_fifo (
		.ref_clk   (ref_clk),
		.rst_b     (rst_b),
		.in_valid  (f_in_valid),
		.in_ready  (f_in_ready),
		.in_data   (link.data_lines),
		.out_valid (f_out_valid),
		.out_ready (f_out_ready),
		.out_data  (f_out_data),
		.level     (f_level)
	);

	//////////////////////////////////////////////////////////////////////
	// register port and sequencer
	always_comb
	begin
		n = q;
		n.sel_b = 1'b0;
		n.rcw = CMD_NOP;
		n.dq_oe = 1'b0;
		n.rdata = '0;
		if (reg_wr)
		begin
			case (reg_addr)
				REG_CMD:
				begin
					if (!q.pend)
					begin
						n.op = reg_wdata[5:0];
						n.pend = 1'b1;
					end
				end
				REG_ADDR:  n.areg = reg_wdata[11:0];
				REG_WDATA: n.wdata = reg_wdata[DW-1:0];
				REG_MASK:  n.mask = reg_wdata[1:0];
				REG_GATE:  n.gate_req = reg_wdata[0];
				default: ;
			endcase
		end
		if (reg_rd)
		begin
			case (reg_addr)
				REG_CMD:   n.rdata = 32'(q.op);
				REG_ADDR:  n.rdata = 32'(q.areg);
				REG_WDATA: n.rdata = 32'(q.wdata);
				REG_MASK:  n.rdata = 32'(q.mask);
				REG_GATE:  n.rdata = 32'(q.gate_req);
				REG_STATUS:
					n.rdata = 32'({q.gate_req, f_level, !f_in_ready,
						!f_out_valid, (q.st != ST_IDLE) || q.pend});
				REG_RDATA: n.rdata = f_out_valid ? 32'(f_out_data) : 32'h0;
				default: n.rdata = 32'h0;
			endcase
		end
		case (q.st)
			ST_INIT_PRE:
			begin
				n.rcw = CMD_PRE;
				n.addr[AP_BIT] = 1'b1;
				n.st = ST_INIT_MRS;
			end
			ST_INIT_MRS:
			begin
				// every bank was just closed
				n.rcw = CMD_MRS;
				n.bank = 2'h0;
				n.addr = MODE_OPCODE;
				n.st = ST_WAIT;
				n.cnt = GAP_CYC;
			end
			ST_IDLE:
			begin
				// no command may share its cycle with a falling gate
				if (n.gate_req)
					n.st = ST_IDLE;
				else if (q.ref_due)
				begin
					n.rcw = CMD_REF;
					n.ref_due = 1'b0;
					n.st = ST_WAIT;
					n.cnt = RC_CYC;
				end
				else if (q.pend && (op != CMD_RD || f_in_ready))
				begin
					n.pend = 1'b0;
					n.rcw = op;
					n.bank = q.op[CMD_BANK_LSB +: 2];
					n.addr = q.areg;
					if (op != CMD_ACT && op != CMD_MRS)
						n.addr[AP_BIT] = q.op[CMD_AP_BIT];
					n.st = ST_WAIT;
					n.cnt = GAP_CYC;
					if (op == CMD_WR)
					begin
						n.dq = q.wdata;
						n.dq_oe = 1'b1;
					end
					if (op == CMD_RD)
					begin
						n.st = ST_RDWAIT;
						n.cnt = {1'b0, CAS_LAT};
					end
				end
			end
			ST_WAIT, ST_RDWAIT:
			begin
				if (q.cnt == 4'h0)
					n.st = ST_IDLE;
				else
					n.cnt = 4'(q.cnt - 4'h1);
			end
			default: n.st = ST_IDLE;
		endcase
		// a due refresh raised here wins over the clear above
		if (q.rcnt == RCW'(REF_GAP - 1))
		begin
			n.rcnt = '0;
			n.ref_due = 1'b1;
		end
		else
			n.rcnt = RCW'(q.rcnt + 1'b1);
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			q <= RST;
		else
			q <= n;
	end

	assign link.clk_gate       = !q.gate_req;
	assign link.sel_b          = q.sel_b;
	assign link.row_strobe_b   = q.rcw[2];
	assign link.col_strobe_b   = q.rcw[1];
	assign link.write_strobe_b = q.rcw[0];
	assign link.bank_select    = q.bank;
	assign link.addr           = q.addr;
	// masks held steadily, so they lead read data by two cycles
	assign link.low_byte_mask  = q.mask[0];
	assign link.high_byte_mask = q.mask[1];
	assign link.ctl_dq_o       = q.dq;
	assign link.ctl_dq_oe      = q.dq_oe;
	assign reg_rdata           = q.rdata;
endmodule

//--- sdp_device.sv
// Operation
// - row-open latches full 12-bit row address; model keeps only the low ROW_BITS bits
// - column from low address bits, 10 or 9
// - bit ten requests auto-precharge on access
// - row-close: bit ten all banks, else one
// - mode-load loads address as configuration
// - commands apply to the selected bank
// - command decoded from three strobes together
// - edge ignored while clock gate low
// - gate low: power-down, suspend or self refresh
// - inputs sampled on rising edge; gate asynchronous (model samples gate on the rising edge too)
// - device select high ignores commands, holds state
// - read lane floats while its mask high
// - write lane discarded while its mask high
// - controller drives writes, device drives reads
// - two masks for x16, one for x8
// - read enable follows mask two cycles earlier
// - controller refreshes 4096 times per 64 ms; controller issues none while the gate is held low
// - mode-load only with every bank idle
`timescale 1ns/1ps
module sdp_device #(
	parameter int DW       = sdp_pkg::DATA_W,
	parameter int ROW_BITS = 4,
	parameter int COL_BITS = 4
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	sdp_link_if.dev          link,
	output sdp_pkg::sdp_pwr_t power_state,
	output logic [11:0]      mode_word
);
	import sdp_pkg::*;

	localparam int LANES = DW / 8;
	localparam int COLW  = (DW == 16) ? COL_W_X16 : COL_W_X8;
	localparam int MAW   = 2 + ROW_BITS + COL_BITS;
	localparam int DEPTH = 1 << MAW;

	typedef struct packed {
		logic [11:0]                      mode;
		logic [BANKS-1:0]                 open;
		logic [BANKS-1:0][ROW_BITS-1:0]   row;
		logic [1:0]                       bbank;
		logic [COL_BITS-1:0]              bstart;
		logic [2:0]                       bidx;
		logic [3:0]                       brem;
		logic                             bwr;
		logic                             bap;
		logic [1:0]                       pv;
		logic [1:0][DW-1:0]               pd;
		logic [DW-1:0]                    dout;
		logic [LANES-1:0]                 oe;
		logic [LANES-1:0]                 mhist;
		sdp_pwr_t                         pwr;
		logic                             cke_prev;
	} sdp_dev_st_t;

	sdp_dev_st_t       q;
	sdp_dev_st_t       n;
	logic [DW-1:0]     mem [DEPTH];
	logic [LANES-1:0]  mask_in;
	logic [COLW-1:0]   col_in;
	logic [MAW-1:0]    idx;
	logic              wr_en;
	logic              fetch;
	sdp_cmd_t          cmd;
	logic [1:0]        bank;
	logic              ap;
	logic [2:0]        cl;
	logic [2:0]        blm;
	logic              ilv;

	function automatic logic [MAW-1:0] mem_index(
		input logic [1:0]          b,
		input logic [ROW_BITS-1:0] r,
		input logic [COL_BITS-1:0] c
	);
		return {b, r, c};
	endfunction

	// column of a burst beat, wrapping inside the burst block
	function automatic logic [COL_BITS-1:0] beat_col(
		input logic [COL_BITS-1:0] s,
		input logic [2:0]          i,
		input logic [2:0]          m,
		input logic                il
	);
		logic [2:0] lo;
		lo = il ? (s[2:0] ^ i) : 3'(s[2:0] + i);
		return {s[COL_BITS-1:3], (s[2:0] & ~m) | (lo & m)};
	endfunction

	generate
		if (LANES == 1)
		begin : g_x8
			assign mask_in = link.low_byte_mask;
		end
		else
		begin : g_x16
			assign mask_in = {link.high_byte_mask, link.low_byte_mask};
		end
	endgenerate

	assign cmd    = sdp_cmd_t'({link.row_strobe_b, link.col_strobe_b,
		link.write_strobe_b});
	assign bank   = link.bank_select;
	assign ap     = link.addr[AP_BIT];
	assign col_in = link.addr[COLW-1:0];
	assign cl     = q.mode[CL_LSB +: 3];
	assign ilv    = q.mode[BT_BIT];

	always_comb
	begin
		case (q.mode[BL_LSB +: 3])
			3'h1: blm = 3'h1;
			3'h2: blm = 3'h3;
			3'h3: blm = 3'h7;
			default: blm = 3'h0;
		endcase
	end

	//////////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		n = q;
		wr_en = 1'b0;
		fetch = 1'b0;
		idx = '0;
		n.cke_prev = link.clk_gate;
		if (!link.clk_gate)
		begin
			// entry into a low-power state on the falling gate
			if (q.cke_prev)
			begin
				if (!link.sel_b && cmd == CMD_REF)
					n.pwr = PS_SELF;
				else if (q.pv != 2'h0 || q.brem != 4'h0 || |q.oe)
					n.pwr = PS_SUSPEND;
				else
					n.pwr = PS_PDOWN;
			end
		end
		else
		begin
			n.pwr = PS_ACTIVE;
			n.mhist = mask_in;
			n.pv = {q.pv[0], 1'b0};
			n.pd[1] = q.pd[0];
			// output stage: latency 2 taps stage 0, latency 3 stage 1
			if (cl == 3'h2)
			begin
				n.oe = {LANES{q.pv[0]}} & ~q.mhist;
				n.dout = q.pd[0];
			end
			else
			begin
				n.oe = {LANES{q.pv[1]}} & ~q.mhist;
				n.dout = q.pd[1];
			end
			if (q.brem != 4'h0)
			begin
				idx = mem_index(q.bbank, q.row[q.bbank],
					beat_col(q.bstart, q.bidx, blm, ilv));
				wr_en = q.bwr;
				fetch = !q.bwr;
				n.bidx = 3'(q.bidx + 3'h1);
				n.brem = 4'(q.brem - 4'h1);
				if (q.brem == 4'h1 && q.bap)
					n.open[q.bbank] = 1'b0;
			end
			if (!link.sel_b)
			begin
				case (cmd)
					CMD_MRS: n.mode = link.addr;
					CMD_ACT:
					begin
						n.open[bank] = 1'b1;
						n.row[bank] = link.addr[ROW_BITS-1:0];
					end
					CMD_PRE:
					begin
						if (ap)
							n.open = '0;
						else
							n.open[bank] = 1'b0;
					end
					CMD_BST: n.brem = 4'h0;
					CMD_RD, CMD_WR:
					begin
						if (q.open[bank])
						begin
							idx = mem_index(bank, q.row[bank],
								col_in[COL_BITS-1:0]);
							wr_en = (cmd == CMD_WR);
							fetch = (cmd == CMD_RD);
							n.bbank = bank;
							n.bstart = col_in[COL_BITS-1:0];
							n.bidx = 3'h1;
							n.brem = {1'b0, blm};
							n.bwr = (cmd == CMD_WR);
							n.bap = ap;
							if (ap && blm == 3'h0)
								n.open[bank] = 1'b0;
						end
					end
					default: ;
				endcase
			end
			if (fetch)
			begin
				n.pv[0] = 1'b1;
				n.pd[0] = mem[idx];
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// state and array
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			q <= '0;
		else
			q <= n;
	end

	always_ff @(posedge ref_clk)
	begin
		if (wr_en)
		begin
			for (int i = 0; i < LANES; i++)
				if (!mask_in[i])
					mem[idx][8*i +: 8] <= link.data_lines[8*i +: 8];
		end
	end

	assign link.dev_dq_o  = q.dout;
	assign link.dev_dq_oe = q.oe;
	assign power_state    = q.pwr;
	assign mode_word      = q.mode;
endmodule

//--- sdp_link_if.sv
`timescale 1ns/1ps
interface sdp_link_if #(parameter int DW = 16);
	localparam int LANES = DW / 8;
	logic              clk_gate;
	logic              sel_b;
	logic              row_strobe_b;
	logic              col_strobe_b;
	logic              write_strobe_b;
	logic [1:0]        bank_select;
	logic [11:0]       addr;
	logic              low_byte_mask;
	logic              high_byte_mask;
	logic [DW-1:0]     ctl_dq_o;
	logic              ctl_dq_oe;
	logic [DW-1:0]     dev_dq_o;
	logic [LANES-1:0]  dev_dq_oe;
	logic [DW-1:0]     data_lines;

	// resolved bus level; an undriven lane reads as zero
	always_comb
	begin
		for (int i = 0; i < LANES; i++)
			data_lines[8*i +: 8] = ctl_dq_oe ? ctl_dq_o[8*i +: 8] :
				dev_dq_oe[i] ? dev_dq_o[8*i +: 8] : 8'h00;
	end

	modport dev (
		input  clk_gate, sel_b, row_strobe_b, col_strobe_b, write_strobe_b,
		input  bank_select, addr, low_byte_mask, high_byte_mask, data_lines,
		output dev_dq_o, dev_dq_oe
	);
	modport ctl (
		output clk_gate, sel_b, row_strobe_b, col_strobe_b, write_strobe_b,
		output bank_select, addr, low_byte_mask, high_byte_mask,
		output ctl_dq_o, ctl_dq_oe,
		input  data_lines
	);
endinterface

//--- sdp_link_sva.sv
`timescale 1ns/1ps
module sdp_link_sva
	import sdp_pkg::*;
	#(parameter int REF_GAP = 20)
(
	input wire logic       ref_clk,
	input wire logic       rst_b,
	input wire logic       clk_gate,
	input wire logic       sel_b,
	input wire logic       row_strobe_b,
	input wire logic       col_strobe_b,
	input wire logic       write_strobe_b,
	input wire logic       low_byte_mask,
	input wire logic       high_byte_mask,
	input wire logic       ctl_dq_oe,
	input wire logic [1:0] dev_dq_oe
);
	localparam int REF_MAX = REF_GAP + 32;
	logic [2:0]  cmd_now;
	logic        live;
	logic        rd_hit;
	logic [15:0] ref_cnt_q;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	assign cmd_now = {row_strobe_b, col_strobe_b, write_strobe_b};
	assign live = clk_gate && !sel_b;
	assign rd_hit = live && cmd_now == CMD_RD;

	// cycles since the last refresh; a low gate resets the count to zero
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			ref_cnt_q <= 16'h0;
		else if (!clk_gate || (live && cmd_now == CMD_REF))
			ref_cnt_q <= 16'h0;
		else
			ref_cnt_q <= ref_cnt_q + 16'h1;
	end

	////////////////////////////////////////////////////////////////////////
	a_low_lane_mask: assert property (
		dev_dq_oe[0] |-> $past(low_byte_mask, 2) == 1'b0)
		else $error("low lane driven with its mask high");
	a_high_lane_mask: assert property (
		dev_dq_oe[1] |-> $past(high_byte_mask, 2) == 1'b0)
		else $error("high lane driven with its mask high");
	a_lane_after_read: assert property (
		dev_dq_oe[0] |-> $past(rd_hit, 3))
		else $error("lane driven without a read three cycles back");
	a_lane_one_beat: assert property (
		dev_dq_oe[0] |=> !dev_dq_oe[0])
		else $error("read beat held longer than one cycle");
	a_write_drives_bus: assert property (
		live && cmd_now == CMD_WR |-> ctl_dq_oe)
		else $error("write issued without bus drive");
	a_no_contention: assert property (
		!(ctl_dq_oe && (|dev_dq_oe)))
		else $error("both ends drive the data lines");
	a_cmd_single: assert property (
		live && cmd_now inside {CMD_ACT, CMD_RD, CMD_WR}
		|=> cmd_now == CMD_NOP)
		else $error("command not followed by idle");
	a_refresh_gap: assert property (
		live && cmd_now == CMD_REF |=> (cmd_now == CMD_NOP) [*8])
		else $error("command inside refresh recovery");
	a_refresh_due: assert property (
		ref_cnt_q <= 16'(REF_MAX))
		else $error("refresh overdue");
	a_gate_freeze: assert property (
		!clk_gate |=> $stable(dev_dq_oe))
		else $error("device moved while clock gated");
endmodule

//--- sdp_pkg.sv
package sdp_pkg;
	localparam int ADDR_W      = 12;
	localparam int BANKS       = 4;
	localparam int DATA_W      = 16;
	localparam int AP_BIT      = 10;
	localparam int COL_W_X16   = 9;
	localparam int COL_W_X8    = 10;
	localparam int BL_LSB      = 0;
	localparam int BT_BIT      = 3;
	localparam int CL_LSB      = 4;
	localparam logic [2:0] CAS_LAT = 3'h3;
	// latency 3, sequential, one beat
	localparam logic [11:0] MODE_OPCODE = 12'h030;
	localparam int CLK_MHZ       = 100;
	localparam int REF_WINDOW_MS = 64;
	localparam int REF_COUNT     = 4096;
	localparam int REF_GAP_CYC   = REF_WINDOW_MS * 1000 * CLK_MHZ / REF_COUNT;
	localparam logic [3:0] RC_CYC  = 4'h7;
	localparam logic [3:0] GAP_CYC = 4'h1;
	localparam int FIFO_DEPTH = 16;
	// controller register map
	localparam int REG_AW = 5;
	localparam logic [4:0] REG_CMD    = 5'h00;
	localparam logic [4:0] REG_ADDR   = 5'h04;
	localparam logic [4:0] REG_WDATA  = 5'h08;
	localparam logic [4:0] REG_MASK   = 5'h0C;
	localparam logic [4:0] REG_STATUS = 5'h10;
	localparam logic [4:0] REG_RDATA  = 5'h14;
	localparam logic [4:0] REG_GATE   = 5'h18;
	localparam int CMD_OP_LSB   = 0;
	localparam int CMD_BANK_LSB = 3;
	localparam int CMD_AP_BIT   = 5;
	localparam int ST_BUSY      = 0;
	localparam int ST_EMPTY     = 1;
	localparam int ST_FULL      = 2;
	localparam int ST_LVL_LSB   = 3;
	localparam int ST_GATE      = 8;
	// {row strobe, column strobe, write strobe}, all active low
	typedef enum logic [2:0] {
		CMD_MRS = 3'h0,
		CMD_REF = 3'h1,
		CMD_PRE = 3'h2,
		CMD_ACT = 3'h3,
		CMD_WR  = 3'h4,
		CMD_RD  = 3'h5,
		CMD_BST = 3'h6,
		CMD_NOP = 3'h7
	} sdp_cmd_t;
	typedef enum logic [1:0] {
		PS_ACTIVE  = 2'h0,
		PS_PDOWN   = 2'h1,
		PS_SUSPEND = 2'h2,
		PS_SELF    = 2'h3
	} sdp_pwr_t;
endpackage

//--- sdram_pin_command_interface_test.sv
`timescale 1ns/1ps
module sdram_pin_command_interface_test;
	import sdp_pkg::*;
	localparam int GAP = 20;
	logic              ref_clk;
	logic              rst_b;
	logic              reg_wr;
	logic              reg_rd;
	logic [REG_AW-1:0] reg_addr;
	logic [31:0]       reg_wdata;
	logic [31:0]       reg_rdata;
	logic [31:0]       v;
	sdp_pwr_t          power_state;
	logic [11:0]       mode_word;
	int                n_errors;
	int                comparisons;
	int                cyc;

	sdp_link_if #(.DW(DATA_W)) link ();
	sdp_device sdp_device_inst (.ref_clk(ref_clk), .rst_b(rst_b),
		.link(link), .power_state(power_state), .mode_word(mode_word));
	sdp_controller #(.REF_GAP(GAP)) sdp_controller_inst (.ref_clk(ref_clk),
		.rst_b(rst_b), .link(link), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));
	sdp_link_sva #(.REF_GAP(GAP)) sdp_link_sva_inst (.ref_clk(ref_clk),
		.rst_b(rst_b), .clk_gate(link.clk_gate), .sel_b(link.sel_b),
		.row_strobe_b(link.row_strobe_b), .col_strobe_b(link.col_strobe_b),
		.write_strobe_b(link.write_strobe_b),
		.low_byte_mask(link.low_byte_mask),
		.high_byte_mask(link.high_byte_mask),
		.ctl_dq_oe(link.ctl_dq_oe), .dev_dq_oe(link.dev_dq_oe));

	////////////////////////////////////////////////////////////////////////
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [4:0] a, output logic [31:0] q);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 q = reg_rdata;
	endtask

	// issue one command and wait for the controller to go idle
	task automatic cmd(input logic [2:0] op, input logic [1:0] bank,
		input logic ap, input logic [11:0] a);
		int n;
		wr(REG_ADDR, {20'h0, a});
		wr(REG_CMD, {26'h0, ap, bank, op});
		repeat (3) @(posedge ref_clk);
		n = 0;
		v = 32'h1;
		while (v[ST_BUSY] && n < 50)
		begin
			rd(REG_STATUS, v);
			n++;
		end
		check(32'(v[ST_BUSY]), 32'h0);
		repeat (4) @(posedge ref_clk);
	endtask

	task automatic wrmem(input logic [1:0] b, input logic [11:0] c,
		input logic [15:0] d, input logic [1:0] m);
		wr(REG_MASK, {30'h0, m});
		wr(REG_WDATA, {16'h0, d});
		cmd(CMD_WR, b, 1'b0, c);
	endtask

	task automatic rdmem(input logic [1:0] b, input logic ap,
		input logic [11:0] c, input logic [15:0] d);
		cmd(CMD_RD, b, ap, c);
		rd(REG_RDATA, v);
		check(v, {16'h0, d});
	endtask

	task automatic expect_empty();
		rd(REG_STATUS, v);
		check(32'(v[ST_EMPTY]), 32'h1);
	endtask

	// a refused read still pushes one word: the idle bus level
	task automatic expect_none();
		rd(REG_RDATA, v);
		check(v, 32'h0);
		expect_empty();
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_errors++;
			results();
		end
	end

	initial
	begin
		rst_b = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = '0;
		reg_wdata = 32'h0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (8) @(posedge ref_clk);
		check(32'(mode_word), 32'(MODE_OPCODE));
		expect_empty();
		for (int b = 0; b < BANKS; b++)
		begin
			cmd(CMD_ACT, 2'(b), 1'b0, 12'(b + 1));
			wrmem(2'(b), 12'(b), 16'hA5C0 + 16'(b), 2'h0);
		end
		for (int b = 0; b < BANKS; b++)
			rdmem(2'(b), 1'b0, 12'(b), 16'hA5C0 + 16'(b));
		wrmem(2'h0, 12'h0, 16'h1234, 2'h1);
		wr(REG_MASK, 32'h0);
		rdmem(2'h0, 1'b0, 12'h0, 16'h12C0);
		wr(REG_MASK, 32'h2);
		rdmem(2'h0, 1'b0, 12'h0, 16'h00C0);
		wr(REG_MASK, 32'h0);
		rdmem(2'h1, 1'b1, 12'h1, 16'hA5C1);
		cmd(CMD_RD, 2'h1, 1'b0, 12'h1);
		expect_none();
		cmd(CMD_PRE, 2'h2, 1'b0, 12'h0);
		cmd(CMD_RD, 2'h2, 1'b0, 12'h2);
		expect_none();
		rdmem(2'h3, 1'b0, 12'h3, 16'hA5C3);
		cmd(CMD_ACT, 2'h2, 1'b0, 12'h5);
		wrmem(2'h2, 12'h2, 16'h5A5A, 2'h0);
		cmd(CMD_PRE, 2'h2, 1'b0, 12'h0);
		cmd(CMD_ACT, 2'h2, 1'b0, 12'h3);
		rdmem(2'h2, 1'b0, 12'h2, 16'hA5C2);
		cmd(CMD_PRE, 2'h0, 1'b1, 12'h0);
		cmd(CMD_RD, 2'h3, 1'b0, 12'h3);
		expect_none();
		cmd(CMD_MRS, 2'h0, 1'b0, 12'h020);
		check(32'(mode_word), 32'h020);
		cmd(CMD_MRS, 2'h0, 1'b0, MODE_OPCODE);
		wr(REG_GATE, 32'h1);
		repeat (4) @(posedge ref_clk);
		check(32'(power_state), 32'(PS_PDOWN));
		rd(REG_STATUS, v);
		check(32'(v[ST_GATE]), 32'h1);
		wr(REG_GATE, 32'h0);
		repeat (4) @(posedge ref_clk);
		check(32'(power_state), 32'(PS_ACTIVE));
		cmd(CMD_ACT, 2'h0, 1'b0, 12'h1);
		for (int i = 0; i < FIFO_DEPTH; i++)
			cmd(CMD_RD, 2'h0, 1'b0, 12'h0);
		rd(REG_STATUS, v);
		check(32'(v[ST_FULL]), 32'h1);
		for (int i = 0; i < FIFO_DEPTH; i++)
		begin
			rd(REG_RDATA, v);
			check(v, 32'h12C0);
		end
		expect_empty();
		results();
	end
endmodule
